// ==== verilog/isd_pkg.sv ====
// Constants for the instruction subset decoder: opcodes, register map,
// field positions and reset values.
// Assumes 10-bit instruction words and a classic Wishbone register bus.
package isd_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned ISD_IW = 10; // Instruction word
  localparam int unsigned ISD_PGW = 6; // Page field
  localparam int unsigned ISD_LOW = 7; // Address within page
  localparam int unsigned ISD_PCW = 13; // Whole counter
  localparam int unsigned ISD_DW = 4; // Accumulator and Y
  localparam int unsigned ISD_DRW = 3; // Register D
  localparam int unsigned ISD_SPW = 3; // Stack pointer
  localparam int unsigned ISD_DEPTH = 8; // Nesting levels
  localparam int unsigned ISD_PDW = 8; // Port D latches

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [4:0] ISD_OP_CALL_DIR_HI = 5'h06; // Top five bits
  localparam logic [9:0] ISD_OP_CALL_IND = 10'h030;
  localparam logic [1:0] ISD_OP_WORD2_HI = 2'h2;
  localparam logic [9:0] ISD_OP_PORT_D_SET = 10'h011;
  localparam logic [9:0] ISD_OP_ACC_INV = 10'h01C;
  localparam logic [9:0] ISD_OP_RC_CLK = 10'h29B;
  localparam logic [9:0] ISD_OP_Y_DEC = 10'h017;
  localparam logic [9:0] ISD_OP_INT_DIS = 10'h004;
  localparam logic [9:0] ISD_OP_INT_EN = 10'h005;
  localparam logic [9:0] ISD_OP_WDT_PERMIT = 10'h29C;
  localparam logic [9:0] ISD_OP_PD_ARM = 10'h05B;
  localparam logic [9:0] ISD_OP_PD_CLOCK = 10'h002;
  localparam logic [9:0] ISD_OP_PD_RAM = 10'h008;
  localparam logic [9:0] ISD_OP_PORT0_RD = 10'h260;
  localparam logic [9:0] ISD_OP_PORT1_RD = 10'h261;
  localparam logic [3:0] ISD_Y_SKIP_VAL = 4'hF; // Skip value after decrement

  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [4:0] ISD_REG_CTRL = 5'h00; // RW run and wake
  localparam logic [4:0] ISD_REG_STATUS = 5'h04; // RO flags
  localparam logic [4:0] ISD_REG_CPU = 5'h08; // RW A, Y, D
  localparam logic [4:0] ISD_REG_PC = 5'h0C; // RO counter
  localparam logic [4:0] ISD_REG_STACK = 5'h10; // RO top of stack
  localparam int unsigned ISD_CTRL_RUN = 0;
  localparam int unsigned ISD_CTRL_WAKE = 1; // Write 1 leaves power-down
  localparam int unsigned ISD_ST_GLOBAL_INTERRUPT_ENABLE_FLAG = 0;
  localparam int unsigned ISD_ST_INT_ACT = 1;
  localparam int unsigned ISD_ST_ARM = 2;
  localparam int unsigned ISD_ST_SKIP = 3;
  localparam int unsigned ISD_ST_WDT = 4;
  localparam int unsigned ISD_ST_RC = 5;
  localparam int unsigned ISD_ST_PDC = 6;
  localparam int unsigned ISD_ST_PDR = 7;
  localparam int unsigned ISD_ST_SP_LSB = 8;
  localparam int unsigned ISD_CPU_A_LSB = 0;
  localparam int unsigned ISD_CPU_Y_LSB = 4;
  localparam int unsigned ISD_CPU_D_LSB = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] ISD_SP_RST = 3'h7; // First push lands in slot 0
  localparam logic [7:0] ISD_PORT_D_RST = 8'h00;
  localparam logic ISD_RUN_RST = 1'b0;

  typedef enum logic [0:0] {ISD_S_FETCH, ISD_S_WORD2} isd_state_t;
endpackage

// ==== verilog/isd_ret_stack.sv ====
// Return-address stack: eight flop slots addressed by index.
// Assumes the caller supplies the already incremented pointer on push.
`timescale 1ns/1ps
module isd_ret_stack (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Push side
  input wire logic push_i,
  input wire logic [isd_pkg::ISD_SPW-1:0] push_idx_i,
  input wire logic [isd_pkg::ISD_PCW-1:0] push_data_i,
  // Read side
  input wire logic [isd_pkg::ISD_SPW-1:0] rd_idx_i,
  output logic [isd_pkg::ISD_PCW-1:0] rd_data_o
);
  import isd_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [ISD_PCW-1:0] slot_r [ISD_DEPTH]; // One return address each

  // One writer per slot
  for (genvar i = 0; i < ISD_DEPTH; i++) begin : g_slot
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        slot_r[i] <= '0;
      end else if (push_i && push_idx_i == ISD_SPW'(i)) begin
        slot_r[i] <= push_data_i;
      end
    end
  end

  // Indexed read
  assign rd_data_o = slot_r[rd_idx_i];
endmodule

// ==== verilog/isd_core.sv ====
// Decode and execute of a subset of a 4-bit CPU instruction set.
// Assumes program memory answers instr_i for pc_page_o/pc_low_o with
// instr_valid_i, and a classic Wishbone master on the register bus.
// Function
// - Direct long call: two words, push, jump.
// - Direct call words 00110 p4-p0, 10 p5 a6-a0.
// - Indirect call pushes; low counter from D and A.
// - Stack holds eight levels; deeper calls overwrite.
// - Clock select picks RC main clock, one cycle.
// - Decrement Y, skip next when result 15.
// - Disable clears enable; effective one cycle later.
// - Enable sets enable; effective one cycle later.
// - Watchdog stop permit set in one cycle.
// - Arming validates a power-down only when it is the very next word.
// - Port zero or one input into accumulator.
// - Unarmed power-down behaves as no operation.
// - Armed: clock mode or RAM back-up mode.
//
// Implementation choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module isd_core (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Program memory
  output logic [isd_pkg::ISD_PGW-1:0] pc_page_o,
  output logic [isd_pkg::ISD_LOW-1:0] pc_low_o,
  input wire logic [isd_pkg::ISD_IW-1:0] instr_i,
  input wire logic instr_valid_i,
  output logic instr_ready_o,
  // Ports
  input wire logic [isd_pkg::ISD_DW-1:0] port0_i,
  input wire logic [isd_pkg::ISD_DW-1:0] port1_i,
  output logic [isd_pkg::ISD_PDW-1:0] port_d_o,
  // Peripheral controls
  output logic int_enable_o,
  output logic rc_clk_sel_o,
  output logic wdt_stop_permit_o,
  output logic pd_clock_mode_o,
  output logic pd_ram_backup_o
);
  import isd_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  isd_state_t state_r; // Fetch or second word
  logic [ISD_PGW-1:0] page_r; // Program counter page
  logic [ISD_LOW-1:0] low_r; // Program counter low
  logic [ISD_DW-1:0] acc_r; // Accumulator
  logic [ISD_DW-1:0] col_y_r; // Column pointer
  logic [ISD_DRW-1:0] reg_d_r; // Register D
  logic [ISD_SPW-1:0] sp_r; // Stack pointer
  logic [4:0] word1_r; // Page bits of first call word
  logic ind_r; // Pending call is indirect
  logic skip_r; // Next word is skipped
  logic global_interrupt_enable_flag_r; // Global interrupt enable flag
  logic global_interrupt_enable_flag_dly_r; // Flag as seen by acceptance
  logic arm_r; // Power-down armed
  logic rc_r; // RC main clock chosen
  logic wdt_r; // Watchdog stop permitted
  logic pdc_r; // Clock operating mode
  logic pdr_r; // RAM back-up mode
  logic [ISD_PDW-1:0] port_d_r; // Port D latches
  logic run_r; // Instruction fetch allowed
  logic ack_r; // Bus answer
  logic [31:0] dat_r; // Bus read data

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic fire; // Word taken this cycle
  logic live; // Word taken in fetch state and not skipped
  logic asleep; // Power-down holds the core
  logic [ISD_PCW-1:0] pc_cur; // Address of current word
  logic [ISD_PCW-1:0] pc_inc; // Next sequential address
  logic [ISD_DW-1:0] y_dec; // Decremented Y
  logic [ISD_PGW-1:0] call_page; // Target page
  logic [ISD_LOW-1:0] call_low; // Target low address
  logic [ISD_SPW-1:0] sp_inc; // Pushed slot index
  logic push; // Stack write
  logic [ISD_PCW-1:0] stack_top; // Slot under pointer
  logic is_w1; // First word cycle
  logic bus_wr; // Write taking effect
  logic wr_cpu; // Write to A, Y, D
  logic wr_ctrl; // Write to control

  assign asleep = pdc_r | pdr_r;
  assign instr_ready_o = run_r & ~asleep;
  assign fire = instr_valid_i & instr_ready_o;
  assign is_w1 = state_r == ISD_S_FETCH;
  assign live = fire & is_w1 & ~skip_r;
  assign pc_cur = {page_r, low_r};
  assign pc_inc = pc_cur + 13'h0001;
  assign y_dec = col_y_r - 4'h1;
  assign sp_inc = sp_r + 3'h1;
  assign bus_wr = cyc_i & stb_i & we_i & ack_r;
  assign wr_cpu = bus_wr & (adr_i == ISD_REG_CPU);
  assign wr_ctrl = bus_wr & (adr_i == ISD_REG_CTRL);

  // Call target from second word
  always_comb begin
    if (ind_r) begin
      call_page = {instr_i[7], instr_i[6], instr_i[3:0]};
      call_low = {reg_d_r, acc_r};
    end else begin
      call_page = {instr_i[7], word1_r};
      call_low = instr_i[6:0];
    end
  end
  assign push = fire & ~is_w1;

  // ----------------------------------------------------------------
  // Return stack
  // ----------------------------------------------------------------
  // eight slots, pointer wraps
  isd_ret_stack u_stack (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .push_i(push),
    .push_idx_i(sp_inc),
    .push_data_i(pc_inc),
    .rd_idx_i(sp_r),
    .rd_data_o(stack_top)
  );

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  // Two-word tracking
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ISD_S_FETCH;
      word1_r <= '0;
      ind_r <= 1'b0;
    end else if (live && instr_i[9:5] == ISD_OP_CALL_DIR_HI) begin
      state_r <= ISD_S_WORD2;
      word1_r <= instr_i[4:0];
      ind_r <= 1'b0;
    end else if (live && instr_i == ISD_OP_CALL_IND) begin
      state_r <= ISD_S_WORD2;
      ind_r <= 1'b1;
    end else if (push) begin
      state_r <= ISD_S_FETCH;
    end
  end
  // Program counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_r <= '0;
      low_r <= '0;
    end else if (push) begin
      page_r <= call_page;
      low_r <= call_low;
    end else if (fire) begin
      {page_r, low_r} <= pc_inc;
    end
  end
  // Stack pointer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sp_r <= ISD_SP_RST;
    end else if (push) begin
      sp_r <= sp_inc;
    end
  end
  // Skip flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      skip_r <= 1'b0;
    end else if (fire && is_w1 && skip_r) begin
      skip_r <= 1'b0;
    end else if (live && instr_i == ISD_OP_Y_DEC) begin
      skip_r <= (y_dec == ISD_Y_SKIP_VAL);
    end
  end

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------
  // Accumulator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_r <= '0;
    end else if (wr_cpu && sel_i[0]) begin
      acc_r <= dat_i[ISD_CPU_A_LSB +: ISD_DW];
    end else if (live && instr_i == ISD_OP_PORT0_RD) begin
      acc_r <= port0_i;
    end else if (live && instr_i == ISD_OP_PORT1_RD) begin
      acc_r <= port1_i;
    end else if (live && instr_i == ISD_OP_ACC_INV) begin
      acc_r <= ~acc_r;
    end
  end
  // Column pointer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      col_y_r <= '0;
    end else if (wr_cpu && sel_i[0]) begin
      col_y_r <= dat_i[ISD_CPU_Y_LSB +: ISD_DW];
    end else if (live && instr_i == ISD_OP_Y_DEC) begin
      col_y_r <= y_dec;
    end
  end
  // Register D, written by software only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_d_r <= '0;
    end else if (wr_cpu && sel_i[1]) begin
      reg_d_r <= dat_i[ISD_CPU_D_LSB +: ISD_DRW];
    end
  end
  // Port D latches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_d_r <= ISD_PORT_D_RST;
    end else if (live && instr_i == ISD_OP_PORT_D_SET) begin
      port_d_r <= '1;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt enable
  // ----------------------------------------------------------------
  // Flag itself
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      global_interrupt_enable_flag_r <= 1'b0;
    end else if (live && instr_i == ISD_OP_INT_DIS) begin
      global_interrupt_enable_flag_r <= 1'b0;
    end else if (live && instr_i == ISD_OP_INT_EN) begin
      global_interrupt_enable_flag_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      global_interrupt_enable_flag_dly_r <= 1'b0;
    end else begin
      global_interrupt_enable_flag_dly_r <= global_interrupt_enable_flag_r;
    end
  end
  assign int_enable_o = global_interrupt_enable_flag_dly_r & is_w1;

  // ----------------------------------------------------------------
  // Clock, watchdog and power-down
  // ----------------------------------------------------------------
  // RC clock choice
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rc_r <= 1'b0;
    end else if (live && instr_i == ISD_OP_RC_CLK) begin
      rc_r <= 1'b1;
    end
  end
  // Watchdog stop permission
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_r <= 1'b0;
    end else if (live && instr_i == ISD_OP_WDT_PERMIT) begin
      wdt_r <= 1'b1;
    end
  end
  // Arming lasts one taken word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arm_r <= 1'b0;
    end else if (fire) begin
      // only the next word sees it
      arm_r <= live && instr_i == ISD_OP_PD_ARM;
    end
  end

  // Power-down modes; entry wins over a wake write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pdc_r <= 1'b0;
      pdr_r <= 1'b0;
    end else if (live && arm_r && (instr_i == ISD_OP_PD_CLOCK || instr_i == ISD_OP_PD_RAM)) begin
      pdc_r <= instr_i == ISD_OP_PD_CLOCK;
      pdr_r <= instr_i == ISD_OP_PD_RAM;
    end else if (wr_ctrl && sel_i[0] && dat_i[ISD_CTRL_WAKE]) begin
      pdc_r <= 1'b0;
      pdr_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // Run control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r <= ISD_RUN_RST;
    end else if (wr_ctrl && sel_i[0]) begin
      run_r <= dat_i[ISD_CTRL_RUN];
    end
  end
  // Answer one cycle after the request, drop the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= cyc_i & stb_i & ~ack_r;
    end
  end
  // Read data captured with the answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= '0;
    end else if (cyc_i && stb_i && !ack_r) begin
      unique case (adr_i)
        ISD_REG_CTRL: dat_r <= {31'h0, run_r};
        ISD_REG_STATUS: dat_r <= {21'h0, sp_r, pdr_r, pdc_r, rc_r, wdt_r,
                                   skip_r, arm_r, int_enable_o, global_interrupt_enable_flag_r};
        ISD_REG_CPU: dat_r <= {21'h0, reg_d_r, col_y_r, acc_r};
        ISD_REG_PC: dat_r <= {19'h0, pc_cur};
        ISD_REG_STACK: dat_r <= {19'h0, stack_top};
        default: dat_r <= 32'h0000_0000;
      endcase
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;
  assign pc_page_o = page_r;
  assign pc_low_o = low_r;
  assign port_d_o = port_d_r;
  assign rc_clk_sel_o = rc_r;
  assign wdt_stop_permit_o = wdt_r;
  assign pd_clock_mode_o = pdc_r;
  assign pd_ram_backup_o = pdr_r;
endmodule

// ==== tb/isd_core_sva.sv ====
// Checker for isd_core: bus answer, fetch step, calls, interrupt flag, power-down.
// Assumes no call, arm, power-down or flag word is ever the skipped word.
`timescale 1ns/1ps
module isd_core_sva (
  // Clock, reset, bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // Fetch
  input wire logic [isd_pkg::ISD_PGW-1:0] pc_page_o,
  input wire logic [isd_pkg::ISD_LOW-1:0] pc_low_o,
  input wire logic [isd_pkg::ISD_IW-1:0] instr_i,
  input wire logic instr_valid_i,
  input wire logic instr_ready_o,
  // Outputs
  input wire logic [isd_pkg::ISD_PDW-1:0] port_d_o,
  input wire logic int_enable_o,
  input wire logic rc_clk_sel_o,
  input wire logic wdt_stop_permit_o,
  input wire logic pd_clock_mode_o,
  input wire logic pd_ram_backup_o
);
  import isd_pkg::*;
  // ----
  // Word tracking
  // ----
  logic take; // Word taken
  logic ex; // Word decoded alone
  logic w2_r; // Between call words
  logic arm_r; // Last word armed
  logic [9:0] w1_r; // Last taken word
  logic [12:0] dir_tgt; // Direct call target
  logic [5:0] ind_pg; // Indirect call page
  assign take = instr_valid_i && instr_ready_o;
  assign ex = take && !w2_r;
  assign dir_tgt = {instr_i[7], w1_r[4:0], instr_i[6:0]};
  assign ind_pg = {instr_i[7:6], instr_i[3:0]};
  // Follow call pairs and arming
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      w2_r <= 1'b0;
      arm_r <= 1'b0;
      w1_r <= 10'h000;
    end else if (take) begin
      w2_r <= !w2_r && (instr_i[9:5] == ISD_OP_CALL_DIR_HI || instr_i == ISD_OP_CALL_IND);
      arm_r <= !w2_r && instr_i == ISD_OP_PD_ARM;
      w1_r <= instr_i;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_next;
    cyc_i && stb_i && !ack_o |=> ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_pc_step;
    ex |=> pc_low_o == $past(pc_low_o) + 7'h01;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc step wrong");
  property p_call_dir;
    take && w2_r && w1_r[9:5] == ISD_OP_CALL_DIR_HI |=> {pc_page_o, pc_low_o} == $past(dir_tgt);
  endproperty
  a_call_dir: assert property (p_call_dir) else $error("direct target wrong");
  property p_call_ind;
    take && w2_r && w1_r == ISD_OP_CALL_IND |=> pc_page_o == $past(ind_pg);
  endproperty
  a_call_ind: assert property (p_call_ind) else $error("indirect page wrong");
  property p_call_mask;
    w2_r |-> !int_enable_o;
  endproperty
  a_call_mask: assert property (p_call_mask) else $error("enable between words");
  property p_ei;
    ex && instr_i == ISD_OP_INT_EN && !int_enable_o |=> !int_enable_o ##1 int_enable_o;
  endproperty
  a_ei: assert property (p_ei) else $error("enable delay wrong");
  property p_di;
    ex && instr_i == ISD_OP_INT_DIS && int_enable_o |=> int_enable_o ##1 !int_enable_o;
  endproperty
  a_di: assert property (p_di) else $error("disable delay wrong");
  property p_pd_clock;
    ex && instr_i == ISD_OP_PD_CLOCK && !pd_clock_mode_o |=> pd_clock_mode_o == $past(arm_r);
  endproperty
  a_pd_clock: assert property (p_pd_clock) else $error("clock mode wrong");
  property p_pd_ram;
    ex && instr_i == ISD_OP_PD_RAM && !pd_ram_backup_o |=> pd_ram_backup_o == $past(arm_r);
  endproperty
  a_pd_ram: assert property (p_pd_ram) else $error("backup mode wrong");
  property p_pd_stall;
    pd_clock_mode_o || pd_ram_backup_o |-> !instr_ready_o;
  endproperty
  a_pd_stall: assert property (p_pd_stall) else $error("fetch in power-down");
  property p_port_d;
    ex && instr_i == ISD_OP_PORT_D_SET |=> port_d_o == 8'hFF;
  endproperty
  a_port_d: assert property (p_port_d) else $error("port d not set");
  property p_rc;
    ex && instr_i == ISD_OP_RC_CLK |=> rc_clk_sel_o && $stable(wdt_stop_permit_o);
  endproperty
  a_rc: assert property (p_rc) else $error("rc select wrong");
  property p_wdt;
    ex && instr_i == ISD_OP_WDT_PERMIT |=> wdt_stop_permit_o;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog permit wrong");
endmodule
bind isd_core isd_core_sva chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .pc_page_o, .pc_low_o, .instr_i,
  .instr_valid_i, .instr_ready_o, .port_d_o, .int_enable_o, .rc_clk_sel_o, .wdt_stop_permit_o,
  .pd_clock_mode_o, .pd_ram_backup_o);

// ==== tb/isd_prog_mem.sv ====
// Program memory model: serves words at the fetch address, a budget at a time.
// Assumes the bench fills mem and loads the budget while idle.
`timescale 1ns/1ps
module isd_prog_mem (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Fetch side
  input wire logic [isd_pkg::ISD_PGW-1:0] pc_page_i,
  input wire logic [isd_pkg::ISD_LOW-1:0] pc_low_i,
  input wire logic ready_i,
  output logic [isd_pkg::ISD_IW-1:0] instr_o,
  output logic valid_o,
  // Bench control
  input wire logic load_i,
  input wire logic [7:0] count_i,
  input wire logic slow_i,
  output logic idle_o
);
  import isd_pkg::*;
  logic [ISD_IW-1:0] mem [0:8191]; // Word store
  logic [7:0] left_r = 8'h00; // Words still to serve
  logic phase_r = 1'b0; // Stall pattern
  logic [ISD_IW-1:0] last_r = 10'h000; // Last word handed over
  initial for (int i = 0; i < 8192; i++) mem[i] = 10'h000;
  assign idle_o = (left_r == 8'h00);
  assign valid_o = !idle_o && (!slow_i || phase_r);
  // Released lines show the inverse of the last word
  assign instr_o = valid_o ? mem[{pc_page_i, pc_low_i}] : ~last_r;
  // Budget and stall pattern
  always @(posedge clk_i) begin
    phase_r <= rst_i ? 1'b0 : (valid_o && !ready_i) ? phase_r : !phase_r; // Hold an offered word
    if (valid_o && ready_i) last_r <= instr_o;
    if (rst_i) left_r <= 8'h00;
    else if (load_i) left_r <= count_i;
    else if (valid_o && ready_i) left_r <= left_r - 8'h01;
  end
endmodule

// ==== tb/isd_core_test.sv ====
// Bench for isd_core: registers, single ops, power-down and nested calls.
// Assumes the memory model and checker are compiled first.
`timescale 1ns/1ps
module isd_core_test;
  import isd_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o, instr_valid_i, instr_ready_o;
  logic [4:0] adr_i = 5'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic [ISD_PGW-1:0] pc_page_o;
  logic [ISD_LOW-1:0] pc_low_o;
  logic [ISD_IW-1:0] instr_i;
  logic [3:0] port0_i = 4'h0, port1_i = 4'h0;
  logic [7:0] port_d_o, cnt = 8'h00;
  logic int_enable_o, rc_clk_sel_o, wdt_stop_permit_o, pd_clock_mode_o, pd_ram_backup_o;
  logic load = 1'b0, slow = 1'b0, idle;
  logic [12:0] pcx; // Expected counter
  logic [31:0] exp_q[$], msk_q[$]; // Read notes
  int errors = 0, check_count = 0;
  isd_core dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .pc_page_o,
    .pc_low_o, .instr_i, .instr_valid_i, .instr_ready_o, .port0_i, .port1_i, .port_d_o, .int_enable_o,
    .rc_clk_sel_o, .wdt_stop_permit_o, .pd_clock_mode_o, .pd_ram_backup_o);
  isd_prog_mem mem_u (.clk_i, .rst_i, .pc_page_i(pc_page_o), .pc_low_i(pc_low_o), .ready_i(instr_ready_o),
    .instr_o(instr_i), .valid_o(instr_valid_i), .load_i(load), .count_i(cnt), .slow_i(slow), .idle_o(idle));
  initial forever #2.5 clk_i = !clk_i;
  // Compare and count
  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Read data against the oldest note
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) compare("read data", exp_q.pop_front(), dat_o & msk_q.pop_front());
  end
  // One classic bus cycle
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
    int n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    if (n >= 40) errors++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    wb(1'b0, a, 32'h0, 4'hF);
  endtask
  // Place words at the expected counter and serve them
  task automatic run(input logic [9:0] w[$]);
    int n = 0;
    foreach (w[i]) mem_u.mem[pcx + 13'(i)] = w[i];
    pcx += 13'(w.size());
    cnt <= 8'(w.size());
    load <= 1'b1;
    @(posedge clk_i);
    load <= 1'b0;
    @(posedge clk_i);
    while (idle !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 200) errors++;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    final_report();
  end
  initial begin
    logic [3:0] a;
    logic [2:0] d;
    logic [5:0] pg;
    logic [6:0] lo;
    void'($urandom(32'hB1A4));
    pcx = 13'h0000;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(ISD_REG_STATUS, 32'h700, 32'h7FF);
    rd(ISD_REG_PC, 32'h0, 32'h1FFF);
    wb(1'b1, 5'h14, 32'hFFFF_FFFF, 4'hF);
    rd(5'h14, 32'h0, 32'hFFFF_FFFF);
    compare("port d", 32'h0, {24'h0, port_d_o});
    wb(1'b1, ISD_REG_CTRL, 32'h1, 4'hF);
    rd(ISD_REG_CTRL, 32'h1, 32'h1);
    $display("test reset done");
    a = 4'($urandom);
    d = 3'($urandom);
    port0_i <= 4'($urandom);
    port1_i <= 4'($urandom);
    wb(1'b1, ISD_REG_CPU, {21'h0, d, 4'h1, a}, 4'hF);
    wb(1'b1, ISD_REG_CPU, {21'h0, ~d, 4'h1, a}, 4'h1);
    run('{ISD_OP_Y_DEC, ISD_OP_ACC_INV});
    rd(ISD_REG_CPU, {21'h0, d, 4'h0, ~a}, 32'h7FF);
    run('{ISD_OP_PORT0_RD, ISD_OP_Y_DEC, ISD_OP_ACC_INV, ISD_OP_PORT_D_SET});
    rd(ISD_REG_CPU, {21'h0, d, 4'hF, port0_i}, 32'h7FF);
    compare("port d", 32'hFF, {24'h0, port_d_o});
    run('{ISD_OP_PORT1_RD, ISD_OP_ACC_INV});
    rd(ISD_REG_CPU, {21'h0, d, 4'hF, ~port1_i}, 32'h7FF);
    $display("test data ops done");
    slow <= 1'b1;
    run('{ISD_OP_INT_EN, ISD_OP_PD_CLOCK, 10'h000});
    rd(ISD_REG_STATUS, 32'h03, 32'hC3);
    run('{ISD_OP_INT_DIS, 10'h000, ISD_OP_PD_ARM, 10'h000, ISD_OP_PD_RAM, ISD_OP_WDT_PERMIT, ISD_OP_RC_CLK});
    rd(ISD_REG_STATUS, 32'h30, 32'hFF);
    slow <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      run('{ISD_OP_PD_ARM});
      rd(ISD_REG_STATUS, 32'h04, 32'h04);
      run('{m ? ISD_OP_PD_RAM : ISD_OP_PD_CLOCK});
      rd(ISD_REG_STATUS, m ? 32'h80 : 32'h40, 32'hC4);
      compare("fetch ready", 32'h0, {31'h0, instr_ready_o});
      wb(1'b1, ISD_REG_CTRL, 32'h3, 4'hF);
    end
    rd(ISD_REG_PC, {19'h0, pcx}, 32'h1FFF);
    $display("test control ops done");
    run('{ISD_OP_INT_EN, 10'h000, 10'h000});
    for (int i = 0; i < 8; i++) begin
      pg = 6'h01 + 6'($urandom % 63);
      lo = 7'($urandom % 96);
      a = 4'($urandom);
      d = 3'($urandom);
      slow <= 1'(i);
      wb(1'b1, ISD_REG_CPU, {21'h0, d, 4'h0, a}, 4'hF);
      if (i[0]) run('{ISD_OP_CALL_IND, {2'b10, pg[5:4], 2'b00, pg[3:0]}});
      else run('{{ISD_OP_CALL_DIR_HI, pg[4:0]}, {2'b10, pg[5], lo}});
      if (i[0]) lo = {d, a};
      rd(ISD_REG_STACK, {19'h0, pcx}, 32'h1FFF);
      pcx = {pg, lo};
      rd(ISD_REG_PC, {19'h0, pcx}, 32'h1FFF);
      rd(ISD_REG_STATUS, {21'h0, 3'(i), 8'h33}, 32'h7FF);
    end
    $display("test calls done");
    final_report();
  end
endmodule
